// ==== rtl/blink_pkg.sv ====
// constants and carrier types for the interval timer led blinker
// assumes a single peripheral clock; no software-visible registers
package blink_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 32_000_000;
	localparam int unsigned TICK_US_RESET   = 2000;
	localparam int unsigned TICK_CYC_RESET  =
		(CLK_HZ / 1_000_000) * TICK_US_RESET;
	localparam int unsigned TICKS_PER_FLIP  = 250;
	localparam int unsigned RELOAD_W        = 16;
	localparam int unsigned TICKCNT_W       = 8;
	localparam int unsigned PRESS_W         = 2;

	// ------------------------------------------------------------
	// reload table, indexed by press count
	// ------------------------------------------------------------
	localparam logic [RELOAD_W-1:0] RELOAD_RESET =
		RELOAD_W'(TICK_CYC_RESET - 1);
	localparam logic [RELOAD_W-1:0] PERIOD_0 = 16'hf9ff; // 64000-1
	localparam logic [RELOAD_W-1:0] PERIOD_1 = 16'h7cff; // 32000-1
	localparam logic [RELOAD_W-1:0] PERIOD_2 = 16'h3e7f; // 16000-1
	localparam logic [RELOAD_W-1:0] PERIOD_3 = 16'h1f3f; // 8000-1
	localparam logic [TICKCNT_W-1:0] TICK_LAST =
		TICKCNT_W'(TICKS_PER_FLIP - 1);
	localparam logic [PRESS_W-1:0] PRESS_RESET = 2'h0;

	// ------------------------------------------------------------
	// edge select codes
	// ------------------------------------------------------------
	localparam logic [1:0] EDGE_NONE    = 2'h0;
	localparam logic [1:0] EDGE_FALLING = 2'h1;
	localparam logic [1:0] EDGE_RISING  = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	// timer channel status carried as one group
	typedef struct packed {
		logic                tick;
		logic [RELOAD_W-1:0] count;
	} timer_status_t;

	typedef enum logic [0:0] {
		TMR_LOAD,
		TMR_COUNT
	} tmr_state_t;

endpackage

// ==== rtl/edge_detect.sv ====
// selectable edge detector for the switch input
// assumes input is synchronous to clock_i
`timescale 1ns/100ps
module edge_detect (
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	// input and selection
	input  wire logic [1:0] sel_i,
	input  wire logic       level_i,
	output logic            event_o
);

	logic prev_q;
	logic event_q;
	wire logic fall = prev_q & ~level_i;
	wire logic rise = ~prev_q & level_i;
	wire logic hit  =
		((sel_i == blink_pkg::EDGE_FALLING) & fall) |
		((sel_i == blink_pkg::EDGE_RISING) & rise) |
		((sel_i == blink_pkg::EDGE_BOTH) & (fall | rise));

	// previous level starts high, as an idle pulled-up switch
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			prev_q  <= 1'b1;
			event_q <= 1'b0;
		end else begin
			prev_q  <= level_i;
			event_q <= hit;
		end
	end

	assign event_o = event_q;

endmodule

// ==== rtl/interval_timer.sv ====
// down-counting interval timer channel
// assumes reload is stable between ticks; no output pin function
`timescale 1ns/100ps
module interval_timer #(
	parameter int unsigned W = blink_pkg::RELOAD_W
) (
	// clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 nrst_i,
	// reload value and status
	input  wire logic [W-1:0]         reload_i,
	output blink_pkg::timer_status_t  status_o
);

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	blink_pkg::tmr_state_t state_q;
	logic [W-1:0]          count_q;
	logic                  tick_q;
	wire logic             at_zero = (count_q == '0);

	// load then count down, tick and reload at zero
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			state_q <= blink_pkg::TMR_LOAD;
			count_q <= '0;
			tick_q  <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			case (state_q)
				blink_pkg::TMR_LOAD: begin
					count_q <= reload_i;
					state_q <= blink_pkg::TMR_COUNT;
				end
				blink_pkg::TMR_COUNT: begin
					if (at_zero) begin
						count_q <= reload_i;
						tick_q  <= 1'b1;
					end else begin
						count_q <= count_q - 1'b1;
					end
				end
				default: state_q <= blink_pkg::TMR_LOAD;
			endcase
		end
	end

	assign status_o = '{tick: tick_q, count: count_q};

endmodule

// ==== rtl/interval_timer_led_blinker.sv ====
// top of the led blinker: timer, tick counter, switch and period table
// assumes switch_i is already synchronous to clock_i; one 32 MHz clock
`timescale 1ns/100ps
module interval_timer_led_blinker #(
	parameter int unsigned TICKS = blink_pkg::TICKS_PER_FLIP
) (
	// clock and reset
	input  wire logic                          clock_i,
	input  wire logic                          nrst_i,
	// switch input, low when pressed
	input  wire logic                          switch_i,
	// led and events
	output logic                               led_output_pin_o,
	output logic                               timer_pin_oe_o,
	output logic                               channel_zero_tick_irq_o,
	output logic                               switch_edge_irq_o,
	output logic [blink_pkg::PRESS_W-1:0]      press_count_o,
	output logic [blink_pkg::RELOAD_W-1:0]     period_reload_reg_o
);

	// ------------------------------------------------------------
	// period table and selection
	// ------------------------------------------------------------
	wire logic [blink_pkg::RELOAD_W-1:0] period_value_table [4] = '{
		blink_pkg::PERIOD_0, blink_pkg::PERIOD_1,
		blink_pkg::PERIOD_2, blink_pkg::PERIOD_3};

	logic [blink_pkg::RELOAD_W-1:0]  period_reload_reg_q;
	logic [blink_pkg::RELOAD_W-1:0]  pending_period_value_q;
	logic [blink_pkg::PRESS_W-1:0]   press_q;
	logic [blink_pkg::TICKCNT_W-1:0] tick_cnt_q;
	logic                            led_q;
	logic                            tick_irq_q;
	logic                            sw_irq_q;

	blink_pkg::timer_status_t tmr;
	logic                     sw_event;

	// next press count wraps after the fourth entry
	wire logic [blink_pkg::PRESS_W-1:0] press_d =
		press_q + 1'b1;
	wire logic [blink_pkg::TICKCNT_W-1:0] tick_last =
		blink_pkg::TICKCNT_W'(TICKS - 1);
	wire logic flip = tmr.tick & (tick_cnt_q == tick_last);

	// ------------------------------------------------------------
	// timer channel and switch edge detector
	// ------------------------------------------------------------
	interval_timer #(
		.W (blink_pkg::RELOAD_W)
	) u_timer (
		.clock_i  (clock_i),
		.nrst_i   (nrst_i),
		.reload_i (period_reload_reg_q),
		.status_o (tmr)
	);

	edge_detect u_edge (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.sel_i   (blink_pkg::EDGE_FALLING),
		.level_i (switch_i),
		.event_o (sw_event)
	);

	// ------------------------------------------------------------
	// switch press handling
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			press_q                <= blink_pkg::PRESS_RESET;
			pending_period_value_q <= blink_pkg::PERIOD_0;
		end else if (sw_event) begin
			press_q                <= press_d;
			pending_period_value_q <= period_value_table[press_d];
		end
	end

	// ------------------------------------------------------------
	// tick counting, led inversion and reload copy
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			tick_cnt_q          <= '0;
			led_q               <= 1'b0;
			period_reload_reg_q <= blink_pkg::RELOAD_RESET;
		end else if (flip) begin
			tick_cnt_q          <= '0;
			led_q               <= ~led_q;
			period_reload_reg_q <= pending_period_value_q;
		end else if (tmr.tick) begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// registered event outputs
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			tick_irq_q <= 1'b0;
			sw_irq_q   <= 1'b0;
		end else begin
			tick_irq_q <= tmr.tick;
			sw_irq_q   <= sw_event;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign led_output_pin_o        = led_q;
	assign timer_pin_oe_o          = 1'b0;
	assign channel_zero_tick_irq_o = tick_irq_q;
	assign switch_edge_irq_o       = sw_irq_q;
	assign press_count_o           = press_q;
	assign period_reload_reg_o     = period_reload_reg_q;

endmodule

// ==== tb/blinker_monitor.sv ====
// checker for the led blinker top ports
// assumes a bind onto interval_timer_led_blinker; one clock domain
`timescale 1ns/100ps
module blinker_monitor #(
	parameter int unsigned TICKS = 250
) (
	// clock and reset
	input wire logic        clock_i,
	input wire logic        nrst_i,
	// watched ports
	input wire logic        switch_i,
	input wire logic        led_output_pin_o,
	input wire logic        timer_pin_oe_o,
	input wire logic        channel_zero_tick_irq_o,
	input wire logic        switch_edge_irq_o,
	input wire logic [1:0]  press_count_o,
	input wire logic [15:0] period_reload_reg_o
);
	logic [16:0] gap_q;
	logic [15:0] rl_q;
	logic [15:0] rl_prev_q;
	// table entry for the current press count
	wire  [15:0] tbl_w = press_count_o == 2'h0 ? blink_pkg::PERIOD_0 :
		press_count_o == 2'h1 ? blink_pkg::PERIOD_1 :
		press_count_o == 2'h2 ? blink_pkg::PERIOD_2 : blink_pkg::PERIOD_3;
	// cycles since the last tick and the reload that timed that countdown;
	// the reload moves at the flip, after the countdown was already loaded,
	// so the value from one cycle before the tick is the one in force
	// reset start absorbs the load cycle and the irq register stage
	always_ff @(posedge clock_i) begin
		rl_prev_q <= period_reload_reg_o;
		if (!nrst_i) begin
			gap_q <= 17'h1fffe;
			rl_q  <= blink_pkg::RELOAD_RESET;
		end else if (channel_zero_tick_irq_o) begin
			gap_q <= 17'h1;
			rl_q  <= rl_prev_q;
		end else begin
			gap_q <= gap_q + 17'h1;
		end
	end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	a_pin_oe_off: assert property (timer_pin_oe_o == 1'b0)
		else $error("timer pin enabled");
	a_tick_single: assert property (
		channel_zero_tick_irq_o |=> !channel_zero_tick_irq_o)
		else $error("tick longer than one cycle");
	a_tick_gap: assert property (channel_zero_tick_irq_o
		|-> gap_q == {1'b0, rl_q} + 17'h1) else $error("tick gap wrong");
	a_flip_tick: assert property (
		$changed(led_output_pin_o) |-> channel_zero_tick_irq_o)
		else $error("led flip without tick");
	a_reload_flip: assert property ($changed(period_reload_reg_o)
		|-> $changed(led_output_pin_o)) else $error("reload moved early");
	a_reload_table: assert property ($changed(period_reload_reg_o)
		|-> period_reload_reg_o == tbl_w) else $error("reload not in table");
	a_press_step: assert property ($changed(press_count_o)
		|-> switch_edge_irq_o && press_count_o == $past(press_count_o) + 2'h1)
		else $error("press count step wrong");
	a_switch_fall: assert property (
		$fell(switch_i) |-> ##2 switch_edge_irq_o)
		else $error("falling edge missed");
endmodule

bind interval_timer_led_blinker blinker_monitor #(.TICKS(TICKS)) mon (
	.clock_i(clock_i), .nrst_i(nrst_i), .switch_i(switch_i),
	.led_output_pin_o(led_output_pin_o), .timer_pin_oe_o(timer_pin_oe_o),
	.channel_zero_tick_irq_o(channel_zero_tick_irq_o),
	.switch_edge_irq_o(switch_edge_irq_o), .press_count_o(press_count_o),
	.period_reload_reg_o(period_reload_reg_o));

// ==== tb/push_switch_model.sv ====
// push switch beside the blinker: pulled high, low while pressed
// assumes the bench clock; the led pin is only an observed load
`timescale 1ns/100ps
module push_switch_model (
	input  wire logic clock_i,
	input  wire logic led_i,
	output logic      switch_o
);
	initial switch_o = 1'b1;
	// hold low four cycles, then back to the pull-up level
	task automatic press();
		@(posedge clock_i);
		switch_o <= 1'b0;
		repeat (4) @(posedge clock_i);
		switch_o <= 1'b1;
		repeat (4) @(posedge clock_i);
	endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the led blinker, one flip per tick
// assumes the bound checker and the push switch model
`timescale 1ns/100ps
module tb_top;
	logic        clock_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        sw_w, led_w, oe_w, tick_w, irq_w;
	logic [1:0]  press_w;
	logic [15:0] rl_w;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          since = 0;
	int          events = 0;
	int          n;
	logic [1:0]  rows [7] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
	push_switch_model sw (.clock_i(clock_i), .led_i(led_w), .switch_o(sw_w));
	interval_timer_led_blinker #(.TICKS(1)) dut (.clock_i(clock_i),
		.nrst_i(nrst_i), .switch_i(sw_w), .led_output_pin_o(led_w),
		.timer_pin_oe_o(oe_w), .channel_zero_tick_irq_o(tick_w),
		.switch_edge_irq_o(irq_w), .press_count_o(press_w),
		.period_reload_reg_o(rl_w));
	always #4 clock_i = ~clock_i;
	// clock edges since reset was released
	always @(posedge clock_i) since <= nrst_i ? since + 1 : 0;
	// cycle ceiling and switch event count
	always @(negedge clock_i) begin
		cycles++;
		if (irq_w === 1'b1) events++;
		if (cycles == 90000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_tick();
		n = 0;
		do begin
			@(negedge clock_i);
			n++;
		end while (tick_w !== 1'b1 && n < 70000);
		if (tick_w !== 1'b1) mismatches++;
	endtask
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(negedge clock_i);
		check(rl_w, 16'hf9ff);
		for (int i = 0; i < 7; i++) begin
			n = events;
			sw.press();
			@(negedge clock_i);
			check(16'(press_w), 16'(rows[i]));
			check(16'(events - n), 16'h1);
			check(rl_w, blink_pkg::PERIOD_0);
		end
		check(16'(led_w), 16'h0);
		wait_tick();
		check(16'(led_w), 16'h1);
		check(rl_w, blink_pkg::PERIOD_3);
		check(16'(since), blink_pkg::RELOAD_RESET + 16'h3);
		@(posedge clock_i);
		nrst_i <= 1'b0;
		repeat (2) @(negedge clock_i);
		check({led_w, oe_w, press_w}, 16'h0);
		check(rl_w, 16'hf9ff);
		@(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (2) @(negedge clock_i);
		check({tick_w, irq_w, led_w}, 16'h0);
		final_report();
	end
endmodule
